// >>> logic/pps_params.svh
/*
 * Constants of the peripheral serial port setup block: register offsets,
 * field positions, codes and timing figures.
 * Assumes inclusion by bare name from the package, the checker and the testbench.
 */
`ifndef PPS_PARAMS_SVH
`define PPS_PARAMS_SVH

// Register word addresses.
`define PPS_ADDR_PORT_MODE   16'h19fa
`define PPS_ADDR_LINE_PARAM  16'h19fb
`define PPS_ADDR_TX_DELAY    16'h19fc
`define PPS_ADDR_MSG_CTRL    16'h19fd
`define PPS_ADDR_DELIMITERS  16'h19fe
`define PPS_ADDR_STATUS      16'h19ff
`define PPS_REG_RESET        16'h0000

// Field codes.
`define PPS_PORT_STANDARD    8'h00
`define PPS_PORT_CUSTOM      8'h01
`define PPS_PROTO_LINK       4'h0
`define PPS_PROTO_RS232      4'h1
`define PPS_START_ON         4'h1
`define PPS_END_COUNT        4'h0
`define PPS_END_CODE         4'h1
`define PPS_END_CRLF         4'h2
`define PPS_BAUD_1200        8'h00
`define PPS_BAUD_2400        8'h01
`define PPS_BAUD_4800        8'h02
`define PPS_BAUD_9600        8'h03
`define PPS_BAUD_19200       8'h04
`define PPS_FMT_GROUP        4'd6
`define PPS_FMT_HALF         4'd3
`define PPS_FMT_MAX          4'd11
`define PPS_CHAR_CR          8'h0d
`define PPS_CHAR_LF          8'h0a
`define PPS_CHAR_LINK_HEAD   8'h40
`define PPS_STAT_PERR        0
`define PPS_STAT_FERR        1
`define PPS_STAT_OVR         2
`define PPS_STAT_BUSY        3

// Timing.
`define PPS_CLK_HZ           40000000
`define PPS_OVERSAMPLE       16
`define PPS_DIV(baud)        (`PPS_CLK_HZ / (`PPS_OVERSAMPLE * (baud)))
`define PPS_MS_HZ            1000
`define PPS_MS_CYCLES        (`PPS_CLK_HZ / `PPS_MS_HZ)
`define PPS_SAMPLE_MID       4'd7
`define PPS_SAMPLE_END       4'd15
`define PPS_FIFO_DEPTH       16
`define PPS_FIFO_WIDTH       9

`endif

// >>> logic/pps_pkg.sv
/*
 * Types shared by the peripheral serial port setup modules.
 * Assumes the constants header is on the include path.
 */
package pps_pkg;
`include "pps_params.svh"

   // Character format chosen for the receiver.
   typedef struct packed {
      logic       data8;
      logic       stop2;
      logic [1:0] parity;
   } pps_fmt_s;

   typedef enum logic [1:0] {
      PPS_PAR_EVEN = 2'b00,
      PPS_PAR_ODD  = 2'b01,
      PPS_PAR_NONE = 2'b10
   } pps_par_e;

   // One word of the receive buffer.
   typedef struct packed {
      logic       last;
      logic [7:0] data;
   } pps_word_s;
endpackage

// >>> logic/pps_fifo.sv
/*
 * Synchronous FIFO with valid and ready on both sides and a registered
 * read port.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps
module pps_fifo import pps_pkg::*; #(
   parameter int WIDTH = `PPS_FIFO_WIDTH,
   parameter int DEPTH = `PPS_FIFO_DEPTH
) (
   input  wire logic             clk_sys_i,
   input  wire logic             rst_n_i,
   input  wire logic [WIDTH-1:0] in_data_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   output logic      [WIDTH-1:0] out_data_o,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;

   ////////////////////////////////////////////////////////////////////////
   // Handshake terms; the output register counts as a separate stage.
   wire push = in_valid_i && in_ready_o;
   wire pop  = (count != '0) && (!out_valid_o || out_ready_i);

   // Full is honest: ready drops once every array slot is taken.
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         wr_ptr      <= '0;
         rd_ptr      <= '0;
         count       <= '0;
         in_ready_o  <= 1'b1;
         out_valid_o <= 1'b0;
         out_data_o  <= '0;
      end else begin
         if (push) begin
            mem[wr_ptr] <= in_data_i;
            wr_ptr      <= wr_ptr + 1'b1;
         end
         if (pop) begin
            out_data_o <= mem[rd_ptr];
            rd_ptr     <= rd_ptr + 1'b1;
         end
         if (pop || out_ready_i) begin
            out_valid_o <= pop;
         end
         count      <= count + (AW+1)'(push) - (AW+1)'(pop);
         in_ready_o <= (count + (AW+1)'(push) - (AW+1)'(pop)) < (AW+1)'(DEPTH);
      end
   end
endmodule

// >>> logic/pps_rx.sv
/*
 * Asynchronous character receiver on a sixteen-times oversample enable.
 * Assumes the line input is already synchronous to the clock.
 */
`timescale 1ns/1ps
module pps_rx import pps_pkg::*; (
   input  wire logic       clk_sys_i,
   input  wire logic       rst_n_i,
   input  wire logic       tick_i,
   input  wire logic       rxd_i,
   input  pps_fmt_s        fmt_i,
   output logic [7:0]      char_o,
   output logic            valid_o,
   output logic            perr_o,
   output logic            ferr_o
);
   typedef enum logic [2:0] {
      RX_IDLE  = 3'b000,
      RX_START = 3'b001,
      RX_DATA  = 3'b010,
      RX_PAR   = 3'b011,
      RX_STOP  = 3'b100
   } pps_rx_e;

   pps_rx_e    state;
   logic [3:0] os_cnt;
   logic [2:0] bit_cnt;
   logic [7:0] shift;
   logic       par_acc;
   logic       stop_two;

   ////////////////////////////////////////////////////////////////////////
   // Decode of sample points and the last data bit.
   wire mid       = os_cnt == `PPS_SAMPLE_MID;
   wire fin       = os_cnt == `PPS_SAMPLE_END;
   wire last_bit  = bit_cnt == (fmt_i.data8 ? 3'd7 : 3'd6);
   wire par_bad   = (par_acc ^ rxd_i) != (fmt_i.parity == PPS_PAR_ODD);
   wire [7:0] out = fmt_i.data8 ? shift : {1'b0, shift[7:1]};

   // Start bit is rechecked at mid-bit so a glitch does not open a frame.
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         state <= RX_IDLE;
         os_cnt <= '0;
         bit_cnt <= '0;
         shift <= '0;
         par_acc <= 1'b0;
         stop_two <= 1'b0;
         char_o <= '0;
         valid_o <= 1'b0;
         perr_o <= 1'b0;
         ferr_o <= 1'b0;
      end else begin
         valid_o <= 1'b0;
         perr_o  <= 1'b0;
         ferr_o  <= 1'b0;
         if (tick_i) begin
            os_cnt <= os_cnt + 1'b1;
            case (state)
               RX_IDLE: begin
                  os_cnt <= '0;
                  if (!rxd_i) begin
                     state <= RX_START;
                  end
               end
               RX_START: begin
                  if (mid) begin
                     os_cnt  <= '0;
                     bit_cnt <= '0;
                     par_acc <= 1'b0;
                     state   <= rxd_i ? RX_IDLE : RX_DATA;
                  end
               end
               RX_DATA: begin
                  if (fin) begin
                     shift   <= {rxd_i, shift[7:1]};
                     par_acc <= par_acc ^ rxd_i;
                     bit_cnt <= bit_cnt + 1'b1;
                     if (last_bit) begin
                        stop_two <= fmt_i.stop2;
                        state <= (fmt_i.parity == PPS_PAR_NONE) ? RX_STOP : RX_PAR;
                     end
                  end
               end
               RX_PAR: begin
                  if (fin) begin
                     perr_o <= par_bad;
                     state  <= RX_STOP;
                  end
               end
               RX_STOP: begin
                  if (fin) begin
                     stop_two <= 1'b0;
                     ferr_o   <= !rxd_i;
                     if (!stop_two || !rxd_i) begin
                        char_o  <= out;
                        valid_o <= rxd_i;
                        state   <= RX_IDLE;
                     end
                  end
               end
               default: state <= RX_IDLE;
            endcase
         end
      end
   end
endmodule

// >>> logic/pps_top.sv
/*
 * Peripheral serial port setup and receive framing: five setup words, a
 * status word, the receiver, message delimiting and the reply delay.
 * Assumes a register master with one-cycle strobes and synchronous pins.
 */
// The address-and-strobe port was decided locally.
// What this block does
// - Port word low byte 00 selects 7 data, even parity, 2 stop, 9600 baud.
// - Port word low byte 01 takes baud and format from the line word.
// - Port word bits 12-15: 0 command-link protocol, 1 plain RS-232C.
// - Line word low byte 00-04 selects 1200, 2400, 4800, 9600, 19200 baud.
// - Line word high byte 00-11 picks data bits, stop bits and parity.
// - Command-link replies wait the delay word in ms, 0000 to 9999.
// - Command-link answers only its BCD node number 00-31 from message word.
// - RS-232C message word bits 8-11 equal to 1 demand a start code.
// - RS-232C end by byte count, by end code, or by CR LF pair.
// - Delimiter word low byte holds the start code, any value.
// - Byte-count end: delimiter high byte 01-FF counts, 00 means 256.
`timescale 1ns/1ps
module pps_top import pps_pkg::*; #(
   parameter int MS_CYCLES = `PPS_MS_CYCLES
) (
   input  wire logic        clk_sys_i,
   input  wire logic        rst_n_i,
   input  wire logic [15:0] reg_addr_i,
   input  wire logic [15:0] reg_wdata_i,
   input  wire logic        reg_write_i,
   input  wire logic        reg_read_i,
   output logic      [15:0] reg_rdata_o,
   input  wire logic        rxd_i,
   output logic      [7:0]  rx_data_o,
   output logic             rx_last_o,
   output logic             rx_valid_o,
   input  wire logic        rx_ready_i,
   output logic             reply_go_o
);
   typedef enum logic [2:0] {
      MS_IDLE  = 3'b000,
      MS_NODE1 = 3'b001,
      MS_NODE2 = 3'b010,
      MS_BODY  = 3'b011,
      MS_DELAY = 3'b100
   } pps_msg_e;

   logic [15:0] port_mode_select;
   logic [15:0] line_parameters;
   logic [15:0] transmit_delay_ms;
   logic [15:0] message_control;
   logic [15:0] message_delimiters;
   logic [2:0]  err_flags;

   ////////////////////////////////////////////////////////////////////////
   // Helper functions.

   // Two BCD digits to binary, used for the format code and the node digits.
   function automatic logic [6:0] bcd2(input logic [7:0] v);
      return 7'(v[7:4]) * 7'd10 + 7'(v[3:0]);
   endfunction

   // Four BCD digits to binary milliseconds.
   function automatic logic [13:0] bcd4(input logic [15:0] v);
      return 14'(bcd2(v[15:8])) * 14'd100 + 14'(bcd2(v[7:0]));
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Field decode of the setup words.
   wire [3:0] proto      = port_mode_select[15:12];
   wire       rs232      = proto == `PPS_PROTO_RS232;
   wire       custom     = port_mode_select[7:0] == `PPS_PORT_CUSTOM;
   wire [7:0] baud_code  = custom ? line_parameters[7:0] : `PPS_BAUD_9600;
   wire [6:0] fmt_code   = bcd2(line_parameters[15:8]);
   wire [3:0] fmt_low    = 4'(fmt_code);
   wire       fmt_hi     = fmt_low >= `PPS_FMT_GROUP;
   wire [3:0] fmt_in_grp = fmt_hi ? fmt_low - `PPS_FMT_GROUP : fmt_low;
   wire       fmt_ok     = fmt_code <= 7'(`PPS_FMT_MAX);
   wire [1:0] fmt_par    = (fmt_in_grp >= `PPS_FMT_HALF) ?
                           2'(fmt_in_grp - `PPS_FMT_HALF) : 2'(fmt_in_grp);
   pps_fmt_s  fmt_cust;
   pps_fmt_s  fmt_std;
   pps_fmt_s  fmt_sel;
   assign fmt_cust = '{data8:  fmt_ok && fmt_hi,
                       stop2:  fmt_ok && (fmt_in_grp >= `PPS_FMT_HALF),
                       parity: fmt_ok ? fmt_par : 2'(PPS_PAR_EVEN)};
   assign fmt_std  = '{data8: 1'b0, stop2: 1'b1, parity: 2'(PPS_PAR_EVEN)};
   assign fmt_sel  = custom ? fmt_cust : fmt_std;

   wire [7:0] node_bcd   = message_control[7:0];
   wire       start_on   = message_control[11:8] == `PPS_START_ON;
   wire [3:0] end_mode   = message_control[15:12];
   wire [7:0] start_code = message_delimiters[7:0];
   wire [7:0] end_byte   = message_delimiters[15:8];
   wire [8:0] end_count  = {end_byte == 8'h00, end_byte};

   ////////////////////////////////////////////////////////////////////////
   // Oversample divider; an unknown baud code falls back to 9600.
   wire [11:0] div_sel =
      (baud_code == `PPS_BAUD_1200)  ? 12'(`PPS_DIV(1200))  :
      (baud_code == `PPS_BAUD_2400)  ? 12'(`PPS_DIV(2400))  :
      (baud_code == `PPS_BAUD_4800)  ? 12'(`PPS_DIV(4800))  :
      (baud_code == `PPS_BAUD_19200) ? 12'(`PPS_DIV(19200)) :
                                       12'(`PPS_DIV(9600));
   logic [11:0] div_cnt;
   logic        os_tick;

   // The enable pulses once per oversample period of the selected rate.
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i || div_cnt >= div_sel - 12'd1) begin
         div_cnt <= '0;
      end else begin
         div_cnt <= div_cnt + 12'd1;
      end
   end
   assign os_tick = div_cnt == '0;

   ////////////////////////////////////////////////////////////////////////
   // Receiver.
   logic [7:0] rx_char;
   logic       rx_char_valid;
   logic       rx_perr;
   logic       rx_ferr;

   pps_rx u_rx (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (rst_n_i),
      .tick_i    (os_tick),
      .rxd_i     (rxd_i),
      .fmt_i     (fmt_sel),
      .char_o    (rx_char),
      .valid_o   (rx_char_valid),
      .perr_o    (rx_perr),
      .ferr_o    (rx_ferr)
   );

   ////////////////////////////////////////////////////////////////////////
   // Pending character: the framer only advances while the buffer accepts,
   // so a full buffer stalls it; a second character meanwhile is overrun.
   logic       pend_valid;
   logic [7:0] pend_char;
   logic       fifo_in_ready;
   wire        step    = pend_valid && fifo_in_ready;
   wire        overrun = rx_char_valid && pend_valid && !step;

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         pend_valid <= 1'b0;
         pend_char  <= '0;
      end else if (rx_char_valid && (!pend_valid || step)) begin
         pend_valid <= 1'b1;
         pend_char  <= rx_char;
      end else if (step) begin
         pend_valid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Message framing decode for the character being stepped.
   pps_msg_e    msg_state;
   logic [8:0]  byte_cnt;
   logic [7:0]  prev_char;
   logic [3:0]  node_hi;
   logic [13:0] delay_ms;
   logic [15:0] ms_cnt;

   wire [8:0] cnt_next = byte_cnt + 9'd1;
   wire end_hit = !rs232 ? pend_char == `PPS_CHAR_CR :
      (end_mode == `PPS_END_COUNT) ? cnt_next == end_count :
      (end_mode == `PPS_END_CODE)  ? pend_char == end_byte :
      (end_mode == `PPS_END_CRLF)  ? (prev_char == `PPS_CHAR_CR &&
                                      pend_char == `PPS_CHAR_LF) : 1'b0;
   wire node_match = bcd2({node_hi, pend_char[3:0]}) == bcd2(node_bcd);
   wire first_ok   = rs232 && !start_on;
   wire start_ok   = rs232 && start_on && pend_char == start_code;
   wire push_char  = step && (msg_state == MS_BODY ||
                     (msg_state == MS_IDLE && first_ok));
   wire delay_done = delay_ms == '0;
   wire ms_tick    = ms_cnt == 16'(MS_CYCLES - 1);

   pps_word_s fifo_in;
   pps_word_s fifo_out;
   assign fifo_in = '{last: end_hit, data: pend_char};

   // Framer; command-link messages end on CR and then start the reply delay.
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         msg_state  <= MS_IDLE;
         byte_cnt   <= '0;
         prev_char  <= '0;
         node_hi    <= '0;
         delay_ms   <= '0;
         ms_cnt     <= '0;
         reply_go_o <= 1'b0;
      end else begin
         reply_go_o <= 1'b0;
         if (step) begin
            prev_char <= pend_char;
         end
         case (msg_state)
            MS_IDLE: begin
               byte_cnt <= '0;
               if (step) begin
                  if (first_ok) begin
                     byte_cnt  <= 9'd1;
                     msg_state <= end_hit ? MS_IDLE : MS_BODY;
                  end else if (start_ok) begin
                     msg_state <= MS_BODY;
                  end else if (!rs232 && pend_char == `PPS_CHAR_LINK_HEAD) begin
                     msg_state <= MS_NODE1;
                  end
               end
            end
            MS_NODE1: begin
               if (step) begin
                  node_hi   <= pend_char[3:0];
                  msg_state <= MS_NODE2;
               end
            end
            MS_NODE2: begin
               if (step) begin
                  msg_state <= node_match ? MS_BODY : MS_IDLE;
               end
            end
            MS_BODY: begin
               if (step) begin
                  byte_cnt <= cnt_next;
                  if (end_hit) begin
                     delay_ms  <= bcd4(transmit_delay_ms);
                     ms_cnt    <= '0;
                     msg_state <= rs232 ? MS_IDLE : MS_DELAY;
                  end
               end
            end
            MS_DELAY: begin
               ms_cnt <= ms_tick ? 16'h0000 : ms_cnt + 16'h0001;
               if (delay_done) begin
                  reply_go_o <= 1'b1;
                  msg_state  <= MS_IDLE;
               end else if (ms_tick) begin
                  delay_ms <= delay_ms - 14'd1;
               end
            end
            default: msg_state <= MS_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Receive buffer between the framer and the user side.
   pps_fifo #(
      .WIDTH (`PPS_FIFO_WIDTH),
      .DEPTH (`PPS_FIFO_DEPTH)
   ) u_fifo (
      .clk_sys_i   (clk_sys_i),
      .rst_n_i     (rst_n_i),
      .in_data_i   (fifo_in),
      .in_valid_i  (push_char),
      .in_ready_o  (fifo_in_ready),
      .out_data_o  (fifo_out),
      .out_valid_o (rx_valid_o),
      .out_ready_i (rx_ready_i)
   );
   assign rx_data_o = fifo_out.data;
   assign rx_last_o = fifo_out.last;

   ////////////////////////////////////////////////////////////////////////
   // Register bus decode.
   wire hit_port  = reg_addr_i == `PPS_ADDR_PORT_MODE;
   wire hit_line  = reg_addr_i == `PPS_ADDR_LINE_PARAM;
   wire hit_delay = reg_addr_i == `PPS_ADDR_TX_DELAY;
   wire hit_ctrl  = reg_addr_i == `PPS_ADDR_MSG_CTRL;
   wire hit_delim = reg_addr_i == `PPS_ADDR_DELIMITERS;
   wire hit_stat  = reg_addr_i == `PPS_ADDR_STATUS;
   wire [2:0] err_set = {overrun, rx_ferr, rx_perr};
   wire [2:0] err_clr = (reg_write_i && hit_stat) ? reg_wdata_i[2:0] : 3'b000;
   wire [15:0] status_word = {12'h000, msg_state != MS_IDLE, err_flags};
   wire [15:0] rd_mux =
      hit_port  ? port_mode_select   :
      hit_line  ? line_parameters    :
      hit_delay ? transmit_delay_ms  :
      hit_ctrl  ? message_control    :
      hit_delim ? message_delimiters :
      hit_stat  ? status_word        : 16'h0000;

   // Setup words change the framing at once, even mid-message.
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         port_mode_select   <= `PPS_REG_RESET;
         line_parameters    <= `PPS_REG_RESET;
         transmit_delay_ms  <= `PPS_REG_RESET;
         message_control    <= `PPS_REG_RESET;
         message_delimiters <= `PPS_REG_RESET;
      end else if (reg_write_i) begin
         if (hit_port)  port_mode_select   <= reg_wdata_i;
         if (hit_line)  line_parameters    <= reg_wdata_i;
         if (hit_delay) transmit_delay_ms  <= reg_wdata_i;
         if (hit_ctrl)  message_control    <= reg_wdata_i;
         if (hit_delim) message_delimiters <= reg_wdata_i;
      end
   end

   // Error flags: write one to clear; a new event in the same cycle wins.
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         err_flags   <= '0;
         reg_rdata_o <= '0;
      end else begin
         err_flags   <= (err_flags & ~err_clr) | err_set;
         reg_rdata_o <= reg_read_i ? rd_mux : 16'h0000;
      end
   end
endmodule

// >>> testbench/pps_host_model.sv
/* Host side of the serial line: sends characters to the port.
   Assumes bit times are given in clock cycles of the system clock. */
`timescale 1ns/1ps
module pps_host (
   input  wire logic clk_sys_i,
   output logic      txd_o
);
   // The line idles high between characters, as an idle asynchronous line does.
   initial txd_o = 1'b1;

   // One character, LSB first, one start bit, no parity and one stop bit.
   task automatic send(input logic [7:0] ch, input int nbits, input int per);
      txd_o <= 1'b0;
      repeat (per) @(posedge clk_sys_i);
      for (int i = 0; i < nbits; i++) begin
         txd_o <= ch[i];
         repeat (per) @(posedge clk_sys_i);
      end
      txd_o <= 1'b1;
      repeat (per) @(posedge clk_sys_i);
   endtask
endmodule

// >>> testbench/pps_top_assertions.sv
/* Port-level checker for the serial port setup block.
   Assumes it is bound to pps_top and sees only its ports. */
`timescale 1ns/1ps
`include "pps_params.svh"
module pps_checker import pps_pkg::*; (
   input wire logic        clk_sys_i,
   input wire logic        rst_n_i,
   input wire logic [15:0] reg_addr_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic        reg_write_i,
   input wire logic        reg_read_i,
   input wire logic [15:0] reg_rdata_o,
   input wire logic [7:0]  rx_data_o,
   input wire logic        rx_last_o,
   input wire logic        rx_valid_o,
   input wire logic        rx_ready_i,
   input wire logic        reply_go_o
);
   // Shadow of the port word, so that mode and readback can be judged.
   logic [15:0] port_word;
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i)
         port_word <= `PPS_REG_RESET;
      else if (reg_write_i && reg_addr_i == `PPS_ADDR_PORT_MODE)
         port_word <= reg_wdata_i;
   end
   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   // A word offered but not yet taken by the user.
   sequence stall_s;
      rx_valid_o && !rx_ready_i;
   endsequence
   // A read of an address outside the six words of the block.
   sequence hole_rd_s;
      reg_read_i && (reg_addr_i < `PPS_ADDR_PORT_MODE || reg_addr_i > `PPS_ADDR_STATUS);
   endsequence
   rdata_idle_a: assert property (!reg_read_i |=> reg_rdata_o == 16'h0000)
      else $error("read data not zero outside a read answer");
   hole_read_a: assert property (hole_rd_s |=> reg_rdata_o == 16'h0000)
      else $error("unmapped read returned nonzero data");
   port_read_a: assert property (reg_read_i && reg_addr_i == `PPS_ADDR_PORT_MODE
      |=> reg_rdata_o == $past(port_word)) else $error("port word readback wrong");
   go_mode_a: assert property (reply_go_o |-> port_word[15:12] == `PPS_PROTO_LINK)
      else $error("reply pulse outside command-link mode");
   go_pulse_a: assert property (reply_go_o |=> !reply_go_o)
      else $error("reply pulse longer than one cycle");
   valid_hold_a: assert property (stall_s |=> rx_valid_o)
      else $error("offered word withdrawn before it was taken");
   data_hold_a: assert property (stall_s |=> $stable(rx_data_o) && $stable(rx_last_o))
      else $error("offered word changed before it was taken");
   reset_quiet_a: assert property ($rose(rst_n_i)
      |-> !rx_valid_o && !reply_go_o && reg_rdata_o == 16'h0000)
      else $error("outputs active right after reset");
endmodule

bind pps_top pps_checker u_chk (.clk_sys_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_write_i,
   .reg_read_i, .reg_rdata_o, .rx_data_o, .rx_last_o, .rx_valid_o, .rx_ready_i, .reply_go_o);

// >>> testbench/testbench.sv
/* Self-checking bench for pps_top: setup words, framed reception, reply delay.
   Assumes the host model drives the line and a shortened millisecond. */
`timescale 1ns/1ps
`include "pps_params.svh"
module testbench import pps_pkg::*; ;
   localparam int MS  = 10;
   localparam int BIT = 16 * `PPS_DIV(19200);
   logic        clk_sys_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic [15:0] reg_addr_i = 16'h0000;
   logic [15:0] reg_wdata_i = 16'h0000;
   logic        reg_write_i = 1'b0;
   logic        reg_read_i = 1'b0;
   logic        rx_ready_i = 1'b1;
   logic        rxd, rx_last_o, rx_valid_o, reply_go_o, watch_rx = 1'b0;
   logic [15:0] reg_rdata_o;
   logic [7:0]  rx_data_o;
   logic [8:0]  exp_q [$];
   int          fails = 0;
   int          check_count = 0;
   int          cyc = 0;

   pps_top #(.MS_CYCLES(MS)) dut (.clk_sys_i, .rst_n_i, .reg_addr_i, .reg_wdata_i,
      .reg_write_i, .reg_read_i, .reg_rdata_o, .rxd_i(rxd), .rx_data_o, .rx_last_o,
      .rx_valid_o, .rx_ready_i, .reply_go_o);
   pps_host host (.clk_sys_i, .txd_o(rxd));

   // Clock and a ceiling on the run; six characters need about 112k cycles.
   always #12.5 clk_sys_i = ~clk_sys_i;
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 150000) begin
         fails++;
         $display("[ERR] run length expected done seen hang");
         close_out();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic cmp(input string what, input logic [15:0] e, input logic [15:0] g);
      check_count++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", what, e, g);
      end
   endtask
   // Strobes drop for a cycle after each access, so no strobe is set twice at once.
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_write_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_write_i <= 1'b0;
      @(posedge clk_sys_i);
   endtask
   task automatic chk_rd(input logic [15:0] a, input logic [15:0] e);
      reg_addr_i <= a;
      reg_read_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_read_i <= 1'b0;
      @(negedge clk_sys_i);
      cmp($sformatf("register %h", a), e, reg_rdata_o);
      @(posedge clk_sys_i);
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Every taken word is matched against the queue of expected words.
   always @(posedge clk_sys_i) begin
      if (watch_rx && rx_valid_o === 1'b1 && rx_ready_i === 1'b1)
         cmp("rx word", {7'h00, exp_q.size() > 0 ? exp_q.pop_front() : 9'h1ff},
             {7'h00, rx_last_o, rx_data_o});
   end

   initial begin
      logic [15:0] v [5];
      logic [7:0]  lk [4];
      logic [7:0]  sc, d1;
      int          n;
      void'($urandom(32'hd1eb5c13));
      repeat (3) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      @(posedge clk_sys_i);
      // Setup words start at zero, keep what is written, and holes read zero.
      for (int i = 0; i < 5; i++) chk_rd(16'h19fa + 16'(i), 16'h0000);
      for (int i = 0; i < 5; i++) begin
         v[i] = 16'($urandom);
         wr(16'h19fa + 16'(i), v[i]);
      end
      for (int i = 0; i < 5; i++) chk_rd(16'h19fa + 16'(i), v[i]);
      wr(16'h1a00, 16'hffff);
      chk_rd(16'h1a00, 16'h0000);
      $display("test setup words done");
      // Start code then one counted byte at 19200 7N1, user stalling meanwhile.
      sc = {1'b0, 7'($urandom)};
      d1 = {1'b0, 7'($urandom)};
      wr(`PPS_ADDR_PORT_MODE, 16'h1001);
      wr(`PPS_ADDR_LINE_PARAM, 16'h0204);
      wr(`PPS_ADDR_MSG_CTRL, 16'h0100);
      wr(`PPS_ADDR_DELIMITERS, {8'h01, sc});
      exp_q.push_back({1'b1, d1});
      watch_rx <= 1'b1;
      rx_ready_i <= 1'b0;
      host.send(sc, 7, BIT);
      host.send(d1, 7, BIT);
      for (n = 0; rx_valid_o !== 1'b1 && n < 4 * BIT; n++) @(posedge clk_sys_i);
      repeat (4) @(posedge clk_sys_i);
      rx_ready_i <= 1'b1;
      for (n = 0; exp_q.size() > 0 && n < 8; n++) @(posedge clk_sys_i);
      cmp("words left", 16'h0000, 16'(exp_q.size()));
      chk_rd(`PPS_ADDR_STATUS, 16'h0000);
      $display("test start code and count done");
      // Command-link frame to node 12 with a 3 ms reply delay.
      exp_q.push_back({1'b1, `PPS_CHAR_CR});
      lk = '{`PPS_CHAR_LINK_HEAD, 8'h31, 8'h32, `PPS_CHAR_CR};
      wr(`PPS_ADDR_PORT_MODE, 16'h0001);
      wr(`PPS_ADDR_TX_DELAY, 16'h0003);
      wr(`PPS_ADDR_MSG_CTRL, 16'h0012);
      // Timed from the CR word, as the pulse beats the host's last stop bit.
      fork
         for (int i = 0; i < 4; i++) host.send(lk[i], 7, BIT);
         begin
            for (n = 0; rx_valid_o !== 1'b1 && n < 40 * BIT; n++) @(posedge clk_sys_i);
            for (n = 0; reply_go_o !== 1'b1 && n < 4 * MS; n++) @(posedge clk_sys_i);
         end
      join
      cmp("reply delay cycles", 16'(3 * MS), 16'(n));
      cmp("words left", 16'h0000, 16'(exp_q.size()));
      $display("test command link done");
      close_out();
   end
endmodule
